// [core/ckr_apb_if.sv]
// APB slave front end: zero wait state access strobes.
// Assumes a compliant APB master on pclk.
module ckr_apb_if (
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    output logic pready,
    output logic pslverr,
    output logic wr_stb,
    output logic rd_stb
);
    // ************************************************************
    // Access decode.
    // ************************************************************
    // Every access completes in its first access cycle.
    always_comb begin
        pready = 1'b1;
        pslverr = 1'b0;
        wr_stb = psel & penable & pwrite;
        rd_stb = psel & ~penable & ~pwrite;
    end
endmodule // ckr_apb_if

// [core/ckr_pkg.sv]
// Package for the clock interrupt and bus reset register block.
// Assumes an APB slave with 32-bit data on pclk and presetn.
package ckr_pkg;
    // ************************************************************
    // Register offsets (byte addresses).
    // ************************************************************
    localparam logic [11:0] CKR_OFF_INT = 12'h00c; // Interrupt register.
    localparam logic [11:0] CKR_OFF_RST = 12'h010; // Bus reset register.
    localparam logic [11:0] CKR_OFF_MASK = 12'h040; // Extra mask register.
    // ************************************************************
    // Field positions and masks.
    // ************************************************************
    localparam int CKR_NSRC = 6; // Number of clock sources.
    localparam int CKR_FLG_LSB = 0; // Ready flags start here.
    localparam int CKR_FAIL_FLG_BIT = 7; // Clock failure flag.
    localparam int CKR_IE_LSB = 8; // Ready enables start here.
    localparam int CKR_CLR_LSB = 16; // Ready clear strobes start here.
    localparam int CKR_FAIL_CLR_BIT = 23; // Clock failure clear strobe.
    localparam logic [31:0] CKR_RST_MASK = 32'h2260_11ff; // Bus reset bits.
    localparam logic [31:0] CKR_RST_RESET = 32'h0000_0000; // Reset value.
    localparam logic [31:0] CKR_MASK_BITS = 32'h0000_00bf; // Maskable bits.
    localparam logic [31:0] CKR_MASK_RESET = 32'h0000_00bf; // All enabled.
    localparam logic [31:0] CKR_ZERO = 32'h0000_0000; // Zero word.
endpackage : ckr_pkg

// [core/ckr_regs.sv]
// Clock interrupt register and high-speed bus peripheral reset register.
// Assumes an APB master on pclk; oscillator status inputs are
// synchronous to pclk and asserted as single-cycle or level events.
//
// Behaviour
// - Clock failure sets read-only failure flag.
// - Writing one to bit 23 clears failure.
// - Bits 8-10 enable three oscillator ready interrupts.
// - Bits 11-13 enable external and PLL ready.
// - Bits 16-21 written one clear ready flags.
// - Reset bits hold peripherals in reset.
// - Reset register zero wait, resets zero.
// - Stable source sets flag when enabled.
//
// The implementer's own choice: the APB slave port.
module ckr_regs (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [ckr_pkg::CKR_NSRC-1:0] src_ready,
    input wire logic ext_high_osc_fail,
    output logic [31:0] periph_reset,
    output logic clk_irq
);
    import ckr_pkg::*;

    // ************************************************************
    // Bus front end.
    // ************************************************************
    logic wr_stb; // Write takes effect this cycle.
    logic rd_stb; // Setup of a read.

    ckr_apb_if u_apb (
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pready(pready),
        .pslverr(pslverr),
        .wr_stb(wr_stb),
        .rd_stb(rd_stb)
    );

    // Merge a write with byte strobes into an old value.
    function automatic logic [31:0] strb_merge(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return r;
    endfunction

    logic wr_int; // Write to interrupt register.
    logic wr_rst; // Write to bus reset register.
    logic wr_msk; // Write to mask register.
    logic [31:0] int_wd; // Strobe-gated write data, zero on absent lanes.

    always_comb begin
        wr_int = wr_stb && (paddr == CKR_OFF_INT);
        wr_rst = wr_stb && (paddr == CKR_OFF_RST);
        wr_msk = wr_stb && (paddr == CKR_OFF_MASK);
        int_wd = strb_merge(CKR_ZERO, pwdata, pstrb);
    end

    // ************************************************************
    // Ready interrupt enables.
    // ************************************************************
    logic [CKR_NSRC-1:0] ready_ie_reg; // Enables, bits 8 to 13.
    logic [31:0] ie_word; // Enables placed in their register positions.
    logic [31:0] ie_merged; // Enables after a byte-lane write.

    // The merge works on the full word so that only the lane holding
    // the enables can change them; a byte write to lane 0 leaves them.
    always_comb begin
        ie_word = CKR_ZERO;
        ie_word[CKR_IE_LSB +: CKR_NSRC] = ready_ie_reg;
        ie_merged = strb_merge(ie_word, pwdata, pstrb);
    end

    // Software writes the enables; lanes not strobed keep value.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ready_ie_reg <= '0;
        end else if (wr_int) begin
            ready_ie_reg <= ie_merged[CKR_IE_LSB +: CKR_NSRC];
        end
    end

    // A written enable lane must show up in the register next cycle.
    chk_ie_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_int && pstrb[1] |=> ready_ie_reg ==
        $past(pwdata[CKR_IE_LSB +: CKR_NSRC]))
        else $error("enable bits not written");

    // ************************************************************
    // Ready flags and failure flag.
    // ************************************************************
    logic [CKR_NSRC-1:0] src_ready_d_reg; // Last sample of readiness.
    logic [CKR_NSRC-1:0] ready_set; // Rising readiness while enabled.
    logic [CKR_NSRC-1:0] ready_clr; // Write-one clear strobes.
    logic [CKR_NSRC-1:0] ready_flag_reg; // Sticky ready flags.
    logic fail_clr; // Failure clear strobe.
    logic fail_flag_reg; // Sticky failure flag.

    // Edge detector: a source becoming stable is the event.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_ready_d_reg <= '0;
        end else begin
            src_ready_d_reg <= src_ready;
        end
    end

    always_comb begin
        ready_set = src_ready & ~src_ready_d_reg & ready_ie_reg;
        ready_clr = wr_int ? int_wd[CKR_CLR_LSB +: CKR_NSRC]
                           : '0;
        fail_clr = wr_int & int_wd[CKR_FAIL_CLR_BIT];
    end

    ckr_sticky #(.WIDTH(CKR_NSRC)) u_ready (
        .pclk(pclk),
        .presetn(presetn),
        .set_evt(ready_set),
        .clr_evt(ready_clr),
        .flag_reg(ready_flag_reg)
    );

    ckr_sticky #(.WIDTH(1)) u_fail (
        .pclk(pclk),
        .presetn(presetn),
        .set_evt(ext_high_osc_fail),
        .clr_evt(fail_clr),
        .flag_reg(fail_flag_reg)
    );

    // A failure seen in one cycle must be in the flag the next cycle.
    chk_fail_sets_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        ext_high_osc_fail |=> fail_flag_reg)
        else $error("failure flag not set");

    // A clear with no failure in the same cycle must drop the flag.
    chk_fail_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        fail_clr && !ext_high_osc_fail |=> !fail_flag_reg)
        else $error("failure flag not cleared");

    // With neither event nor clear the failure flag must not move.
    chk_fail_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        !ext_high_osc_fail && !fail_clr |=> $stable(fail_flag_reg))
        else $error("failure flag changed by itself");

    // Each enabled rising source must land in its flag.
    chk_ready_set: assert property (
        @(posedge pclk) disable iff (!presetn)
        ready_set != '0 |=> (ready_flag_reg & $past(ready_set))
        == $past(ready_set))
        else $error("ready flag not set");

    // A clear strobe with no competing set must empty its flag.
    chk_ready_clear: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ready_clr != '0) && (ready_set == '0) |=>
        (ready_flag_reg & $past(ready_clr)) == '0)
        else $error("ready flag not cleared");

    // Flags are sticky: without a set or a clear they stay as they are.
    chk_flag_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        (ready_set == '0) && (ready_clr == '0) |=>
        $stable(ready_flag_reg))
        else $error("ready flag changed by itself");

    // ************************************************************
    // Interrupt mask.
    // ************************************************************
    logic [31:0] irq_mask_reg; // One enables the matching status bit.

    // Mask shares the status layout; unused bits stay zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= CKR_MASK_RESET;
        end else if (wr_msk) begin
            irq_mask_reg <= strb_merge(irq_mask_reg, pwdata, pstrb)
                            & CKR_MASK_BITS;
        end
    end

    logic [31:0] status_word; // Flags in their register positions.

    always_comb begin
        status_word = CKR_ZERO;
        status_word[CKR_FLG_LSB +: CKR_NSRC] = ready_flag_reg;
        status_word[CKR_FAIL_FLG_BIT] = fail_flag_reg;
        clk_irq = |(status_word & irq_mask_reg);
    end

    // A request needs a set flag behind it.
    chk_irq_level: assert property (
        @(posedge pclk) disable iff (!presetn)
        clk_irq |-> (ready_flag_reg != '0) || fail_flag_reg)
        else $error("interrupt without flag");

    // An unmasked failure flag must raise the request.
    chk_irq_raise: assert property (
        @(posedge pclk) disable iff (!presetn)
        fail_flag_reg && irq_mask_reg[CKR_FAIL_FLG_BIT] |-> clk_irq)
        else $error("unmasked failure without interrupt");

    // Bits outside the status layout can never be enabled.
    chk_mask_layout: assert property (
        @(posedge pclk) disable iff (!presetn)
        (irq_mask_reg & ~CKR_MASK_BITS) == CKR_ZERO)
        else $error("mask bit outside layout");

    // ************************************************************
    // Peripheral reset register.
    // ************************************************************
    logic [31:0] periph_reset_reg; // One holds a peripheral in reset.

    // Byte-lane writes; reserved bits forced to zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_reset_reg <= CKR_RST_RESET;
        end else if (wr_rst) begin
            periph_reset_reg <= strb_merge(periph_reset_reg, pwdata,
                                           pstrb) & CKR_RST_MASK;
        end
    end

    assign periph_reset = periph_reset_reg;

    // A full-word write lands with only the documented bits kept.
    chk_rst_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_rst && (pstrb == 4'hf) |=>
        periph_reset == ($past(pwdata) & CKR_RST_MASK))
        else $error("reset register write wrong");

    // Without a write the reset bits must hold their peripherals.
    chk_rst_hold: assert property (
        @(posedge pclk) disable iff (!presetn)
        !wr_rst |=> $stable(periph_reset_reg))
        else $error("reset register changed by itself");

    // Reserved bits of the reset register never come up.
    chk_rst_reserved: assert property (
        @(posedge pclk) disable iff (!presetn)
        (periph_reset_reg & ~CKR_RST_MASK) == CKR_ZERO)
        else $error("reserved reset bit set");

    // ************************************************************
    // Read data.
    // ************************************************************
    logic [31:0] prdata_reg; // Captured at setup, valid in access cycle.
    logic [31:0] rd_mux; // Selected register view.

    // Clear strobes read as zero; unmapped offsets read zero.
    always_comb begin
        unique case (paddr)
            CKR_OFF_INT: begin
                rd_mux = status_word;
                rd_mux[CKR_IE_LSB +: CKR_NSRC] = ready_ie_reg;
            end
            CKR_OFF_RST: rd_mux = periph_reset_reg;
            CKR_OFF_MASK: rd_mux = irq_mask_reg;
            default: rd_mux = CKR_ZERO;
        endcase
    end

    // Sampling at setup lets a zero wait state read return stable data.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg <= CKR_ZERO;
        end else if (rd_stb) begin
            prdata_reg <= rd_mux;
        end
    end

    assign prdata = prdata_reg;

    // The slave never stretches an access and never signals an error.
    chk_zero_wait: assert property (
        @(posedge pclk) disable iff (!presetn)
        psel && penable |-> pready && !pslverr)
        else $error("wait state inserted");

    // Reserved positions of the interrupt register read as zero.
    chk_int_reserved: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_stb && (paddr == CKR_OFF_INT) |=>
        (prdata[31:CKR_IE_LSB + CKR_NSRC] == '0)
        && !prdata[CKR_FLG_LSB + CKR_NSRC])
        else $error("reserved interrupt bit read as one");

    // An offset that maps to no register returns zero.
    chk_unmapped_zero: assert property (
        @(posedge pclk) disable iff (!presetn)
        rd_stb && (paddr != CKR_OFF_INT) && (paddr != CKR_OFF_RST)
        && (paddr != CKR_OFF_MASK) |=> prdata == CKR_ZERO)
        else $error("unmapped offset read nonzero");
endmodule // ckr_regs

// [core/ckr_sticky.sv]
// Sticky event bank: hardware sets, a write-one strobe clears.
// Assumes events and clears synchronous to pclk.
module ckr_sticky #(
    parameter int WIDTH = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [WIDTH-1:0] set_evt,
    input wire logic [WIDTH-1:0] clr_evt,
    output logic [WIDTH-1:0] flag_reg
);
    // ************************************************************
    // Flag storage.
    // ************************************************************
    // A set in the same cycle as a clear wins, so no event is lost.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flag_reg <= '0;
        end else begin
            flag_reg <= (flag_reg & ~clr_evt) | set_evt;
        end
    end
endmodule // ckr_sticky

// [tb/ckr_regs_tb.sv]
// Self-checking bench for the clock interrupt and bus reset registers.
// Assumes ckr_regs is an APB slave and this bench is its only master.
module ckr_regs_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ckr_pkg::*;

    // ************************************************************
    // Stimulus and observed signals.
    // ************************************************************
    logic pclk = 1'b0; // Bus clock, 5 ns period.
    logic presetn = 1'b0; // Held low for the first 8 cycles.
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'h0;
    logic [5:0] src_ready = 6'h00; // Oscillator stable levels.
    logic ext_high_osc_fail = 1'b0; // Oscillator failure event.
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] periph_reset;
    logic clk_irq;
    int num_errors = 0; // Mismatches seen.
    int checks = 0; // Comparisons made.

    always #2.5 pclk = ~pclk;

    ckr_regs u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .src_ready(src_ready),
        .ext_high_osc_fail(ext_high_osc_fail),
        .periph_reset(periph_reset), .clk_irq(clk_irq));

    // ************************************************************
    // Bus tasks and comparison.
    // ************************************************************
    // Case equality, so an unknown value never passes.
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer; the request stands until pready is sampled.
    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s,
                       output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] s = 4'hf);
        logic [31:0] q;
        apb(1'b1, a, d, s, q);
    endtask

    // Reads always use an empty strobe, as the bus requires.
    task automatic rd_chk(input string what, input logic [11:0] a,
                          input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0000_0000, 4'h0, q);
        chk(what, q, exp);
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic wrap_up;
        if (num_errors == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // ************************************************************
    // Test sequence.
    // ************************************************************
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("int reset", CKR_OFF_INT, 32'h0000_0000);
        rd_chk("bus reset", CKR_OFF_RST, 32'h0000_0000);
        chk("reset out", periph_reset, 32'h0000_0000);
        // Every writable bit, then clearing one byte lane alone.
        wr(CKR_OFF_RST, 32'hffff_ffff);
        rd_chk("bus all", CKR_OFF_RST, 32'h2260_11ff);
        chk("hold out", periph_reset, 32'h2260_11ff);
        wr(CKR_OFF_RST, 32'h0000_0000, 4'b0010);
        rd_chk("bus lane", CKR_OFF_RST, 32'h2260_00ff);
        rd_chk("unmapped", 12'h080, 32'h0000_0000);
        chk("no error", {31'h0, pslverr}, 32'h0000_0000);
        // Strobes and reserved bits must read back as zero.
        wr(CKR_OFF_INT, 32'hffff_ffff);
        rd_chk("ie all", CKR_OFF_INT, 32'h0000_3f00);
        // Each source: set, a zero strobe keeps it, a one clears it.
        for (int i = 0; i < 6; i++) begin
            src_ready[i] <= 1'b1;
            settle(2);
            rd_chk("flag set", CKR_OFF_INT, 32'h3f00 | (32'h1 << i));
            chk("irq on", {31'h0, clk_irq}, 32'h1);
            src_ready[i] <= 1'b0;
            wr(CKR_OFF_INT, 32'h0000_3f00);
            rd_chk("zero strb", CKR_OFF_INT, 32'h3f00 | (32'h1 << i));
            wr(CKR_OFF_INT, 32'h3f00 | (32'h1 << (16 + i)));
            rd_chk("flag clr", CKR_OFF_INT, 32'h0000_3f00);
            chk("irq off", {31'h0, clk_irq}, 32'h0);
        end
        // Disabled enables keep every source quiet.
        wr(CKR_OFF_INT, 32'h0000_0000);
        src_ready <= 6'h3f;
        settle(2);
        rd_chk("ie off", CKR_OFF_INT, 32'h0000_0000);
        chk("irq quiet", {31'h0, clk_irq}, 32'h0);
        src_ready <= 6'h00;
        // Oscillator failure flag, mask, reserved write, then clear.
        ext_high_osc_fail <= 1'b1;
        @(posedge pclk);
        ext_high_osc_fail <= 1'b0;
        rd_chk("fail set", CKR_OFF_INT, 32'h0000_0080);
        chk("irq fail", {31'h0, clk_irq}, 32'h1);
        wr(CKR_OFF_MASK, 32'h0000_0000);
        rd_chk("mask off", CKR_OFF_MASK, 32'h0000_0000);
        chk("irq mask", {31'h0, clk_irq}, 32'h0);
        wr(CKR_OFF_MASK, 32'h0000_00bf);
        wr(CKR_OFF_INT, 32'h0040_4000);
        rd_chk("rsv write", CKR_OFF_INT, 32'h0000_0080);
        wr(CKR_OFF_INT, 32'h0080_0000);
        rd_chk("fail clr", CKR_OFF_INT, 32'h0000_0000);
        chk("irq clr", {31'h0, clk_irq}, 32'h0);
        // A second reset in mid-run must drop every held peripheral.
        wr(CKR_OFF_RST, 32'h0000_1000);
        wr(CKR_OFF_MASK, 32'h0000_0000);
        rd_chk("crc held", CKR_OFF_RST, 32'h0000_1000);
        presetn <= 1'b0;
        settle(2);
        chk("mid reset", periph_reset, 32'h0000_0000);
        @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("bus again", CKR_OFF_RST, 32'h0000_0000);
        rd_chk("mask again", CKR_OFF_MASK, CKR_MASK_RESET);
        wrap_up();
    end

    // The sequence needs well under a thousand cycles; this cuts a hang.
    initial begin
        repeat (5000) @(posedge pclk);
        num_errors++;
        wrap_up();
    end
endmodule // ckr_regs_tb
